// ---- hw/lspd_top.sv ----
// Link sequencing, poll handshake, precedence and dedup with a bus slave.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Send and receive numbers count 0 to 127 and wrap.
// - At most 127 information frames outstanding per direction.
// - Send counter steps once per new frame and respects the window.
// - Send number copies send counter; group frames send zero, poll zero.
// - Receive counter steps only on a clean in-sequence frame.
// - Frames carry the receive counter as ack; group frames carry zero.
// - Individual acks confirm frames below it; group acks confirm nothing.
// - One poll outstanding per direction until a final arrives.
// - Poll timer expiry allows a fresh poll for recovery.
// - A received poll gets a final response first, top precedence.
// - Responses with final zero may be sent unsolicited.
// - Connectionless acked commands poll; answer final after hold delay.
// - Identification number set at first send, kept on retransmission.
// - No identification number reused while still unacknowledged.
// - History keeps sender, ids, check, octets, count; 255 per sender max.
// - Compare only with entries of same sender and id.
// - Duplicate: equal octets, count under seven, destinations and check.
// - Purge sender history on non-duplicate match or hello/goodbye.
// - Command or response told by source address low bit.
// - Multi-addressed frames share type and control but poll and sequence.
// - Earliest responses queue early with max of queued and mid precedence.
// - Decoupled receive-ready takes precedence of the acknowledged frame.
// - Identification numbers lie in 1 to 255.
// - Information control field: 0, send number, poll/final, receive number.
module lspd_top #(
  parameter int unsigned NCONN = 4,
  parameter int unsigned HIST_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  localparam int unsigned CW = (NCONN > 1) ? $clog2(NCONN) : 1;

  // Bus decode.
  logic ack_q;
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = bus_req & wb_we_i;
  wire [31:0] wd = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire wr_conn = wr & (wb_adr_i == lspd_pkg::ADR_CONN_SEL);
  wire wr_tx = wr & (wb_adr_i == lspd_pkg::ADR_TX_REQ);
  wire wr_rx = wr & (wb_adr_i == lspd_pkg::ADR_RX_FRAME);
  wire wr_poll = wr & (wb_adr_i == lspd_pkg::ADR_POLL_EV);
  wire wr_queue = wr & (wb_adr_i == lspd_pkg::ADR_QUEUE);
  wire wr_diatx = wr & (wb_adr_i == lspd_pkg::ADR_DAF_TX);
  wire wr_daf_a = wr & (wb_adr_i == lspd_pkg::ADR_DAF_RX_A);
  wire wr_daf_b = wr & (wb_adr_i == lspd_pkg::ADR_DAF_RX_B);
  wire wr_daf_c = wr & (wb_adr_i == lspd_pkg::ADR_DAF_RX_C);

  // Per-connection sequence and poll state.
  logic [6:0] vs_q [NCONN];
  logic [6:0] vr_q [NCONN];
  logic [6:0] va_q [NCONN];
  logic [NCONN-1:0] poll_out_q;
  logic [NCONN-1:0] fpend_q;
  logic [CW-1:0] conn_q;
  logic clack_pend_q;
  logic hold_ok_q;
  logic clack_bad_q;
  logic nr_err_q;
  logic [1:0] queue_hi_q;
  logic [31:0] tx_word_q;

  wire [6:0] cur_vs = vs_q[conn_q];
  wire [6:0] cur_vr = vr_q[conn_q];
  wire [6:0] cur_va = va_q[conn_q];
  wire cur_poll_out = poll_out_q[conn_q];
  wire cur_fpend = fpend_q[conn_q];
  wire [6:0] outstanding = cur_vs - cur_va;
  wire win_open = outstanding < lspd_pkg::SEQ_MAX_OUT;

  // Transmit request fields.
  lspd_pkg::lspd_kind_e tx_kind;
  assign tx_kind = lspd_pkg::lspd_kind_e'(wd[1:0]);
  wire tx_grp = wd[2];
  wire tx_poll = wd[3];
  wire [1:0] tx_prec = wd[5:4];
  wire tx_clack = wd[6];
  wire tx_is_i = (tx_kind == lspd_pkg::KIND_I_CMD) |
                 (tx_kind == lspd_pkg::KIND_I_RSP);
  wire tx_is_rsp = (tx_kind == lspd_pkg::KIND_I_RSP) |
                   (tx_kind == lspd_pkg::KIND_S_RSP);
  // A group frame never solicits and never answers, so one control word
  // serves every address of a multi-addressed frame.
  wire cmd_pf = ~tx_grp & tx_poll & ~cur_poll_out;
  wire clack_go = tx_clack & clack_pend_q & hold_ok_q;
  wire rsp_final = ~tx_grp & (cur_fpend | clack_go);
  wire tx_pf = tx_is_rsp ? rsp_final : cmd_pf;
  wire tx_refuse = (tx_is_i & ~tx_grp & ~win_open) |
                   (tx_clack & ~clack_go);
  wire [6:0] tx_ns = tx_grp ? 7'h00 : cur_vs;
  wire [6:0] tx_nr = tx_grp ? 7'h00 : cur_vr;

  lspd_pkg::lspd_ictrl_s tx_ctrl;
  assign tx_ctrl.fmt = 1'b0;
  assign tx_ctrl.ns = tx_ns;
  assign tx_ctrl.pf = tx_pf;
  assign tx_ctrl.nr = tx_nr;
  wire [15:0] s_word = {tx_nr, tx_pf, lspd_pkg::S_RR_LOW};
  wire [15:0] tx_bits = tx_is_i ? 16'(tx_ctrl) : s_word;

  wire [1:0] mid_or_hi = (queue_hi_q > lspd_pkg::PREC_PRIORITY) ?
                         queue_hi_q : lspd_pkg::PREC_PRIORITY;
  wire [1:0] out_prec = (tx_is_rsp & tx_pf) ? lspd_pkg::PREC_TOP :
                        tx_is_rsp ? mid_or_hi : tx_prec;
  wire [1:0] out_qpos = (tx_is_rsp & tx_pf) ? lspd_pkg::QPOS_FIRST :
                        tx_is_rsp ? lspd_pkg::QPOS_EARLIEST :
                        lspd_pkg::QPOS_NORMAL;

  // Received frame fields; the C/R bit is the source address low bit.
  wire [6:0] rx_ns = wd[6:0];
  wire [6:0] rx_nr = wd[lspd_pkg::F_NR +: 7];
  wire rx_pf = wd[lspd_pkg::F_PF];
  wire rx_ok = wd[lspd_pkg::F_FCSOK];
  wire rx_grp = wd[lspd_pkg::F_GROUP];
  wire rx_is_rsp = wd[lspd_pkg::F_CR];
  wire rx_iframe = wd[lspd_pkg::F_IFRAME];
  wire rx_clack = wd[lspd_pkg::F_CLACK];
  wire rx_ind = wr_rx & rx_ok & ~rx_grp;
  wire rx_inseq = rx_ind & rx_iframe & (rx_ns == cur_vr);
  // An ack is only believed if it lies between the oldest unacked frame
  // and the send counter; anything else is flagged, not applied.
  wire rx_nr_ok = (7'(rx_nr - cur_va)) <= outstanding;
  wire rx_poll = rx_ind & ~rx_is_rsp & rx_pf & ~rx_clack;
  wire rx_final = rx_ind & rx_is_rsp & rx_pf;
  wire tx_take = wr_tx & ~tx_refuse;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conn_q <= '0;
      queue_hi_q <= 2'h0;
      tx_word_q <= 32'h0000_0000;
    end else begin
      if (wr_conn) begin
        conn_q <= wd[CW-1:0];
      end
      if (wr_queue) begin
        queue_hi_q <= wd[1:0];
      end
      if (wr_tx) begin
        tx_word_q <= {~tx_refuse, tx_refuse, 10'h000, out_qpos, out_prec,
                      tx_bits};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCONN; c++) begin
        vs_q[c] <= 7'h00;
        vr_q[c] <= 7'h00;
        va_q[c] <= 7'h00;
      end
    end else begin
      if (tx_take && tx_is_i && !tx_grp) begin
        vs_q[conn_q] <= cur_vs + 7'h01;
      end
      if (rx_inseq) begin
        vr_q[conn_q] <= cur_vr + 7'h01;
      end
      if (rx_ind && rx_nr_ok) begin
        va_q[conn_q] <= rx_nr;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      poll_out_q <= '0;
      fpend_q <= '0;
      nr_err_q <= 1'b0;
    end else begin
      if (rx_final || (wr_poll && wd[0])) begin
        poll_out_q[conn_q] <= 1'b0;
      end else if (tx_take && !tx_is_rsp && cmd_pf) begin
        poll_out_q[conn_q] <= 1'b1;
      end
      if (rx_poll) begin
        fpend_q[conn_q] <= 1'b1;
      end else if (tx_take && tx_is_rsp && cur_fpend && !tx_grp) begin
        fpend_q[conn_q] <= 1'b0;
      end
      if (rx_ind && !rx_nr_ok) begin
        nr_err_q <= 1'b1;
      end else if (wr_poll && wd[3]) begin
        nr_err_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clack_pend_q <= 1'b0;
      hold_ok_q <= 1'b0;
      clack_bad_q <= 1'b0;
    end else begin
      if (rx_ind && rx_clack && !rx_is_rsp && rx_pf) begin
        clack_pend_q <= 1'b1;
        hold_ok_q <= 1'b0;
      end else if (tx_take && clack_go) begin
        clack_pend_q <= 1'b0;
        hold_ok_q <= 1'b0;
      end else if (wr_poll && wd[1] && clack_pend_q) begin
        hold_ok_q <= 1'b1;
      end
      if (rx_ind && rx_clack && !rx_is_rsp && !rx_pf) begin
        clack_bad_q <= 1'b1;
      end else if (wr_poll && wd[2]) begin
        clack_bad_q <= 1'b0;
      end
    end
  end

  // Identification numbers for outgoing decoupled data frames.
  logic id_ready;
  logic [7:0] id_cur;
  logic [7:0] daf_id_q;
  logic [1:0] daf_prec_q;
  logic daf_refused_q;
  wire id_assign = wr_diatx & wd[0];

  lspd_idalloc u_idalloc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .assign_i(id_assign),
    .release_i(wr_diatx & wd[1]),
    .release_id_i(wd[15:8]),
    .ready_o(id_ready),
    .id_o(id_cur)
  );

  // Software keeps the returned number with the frame and reuses it on
  // every retransmission; only a first send asks for a new one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      daf_id_q <= 8'h00;
      daf_prec_q <= 2'h0;
      daf_refused_q <= 1'b0;
    end else if (id_assign) begin
      daf_refused_q <= ~id_ready;
      if (id_ready) begin
        daf_id_q <= id_cur;
        daf_prec_q <= wd[5:4];
      end
    end
  end

  // Duplicate detection for received decoupled data frames.
  lspd_pkg::lspd_hist_s rx_hist_q;
  lspd_pkg::lspd_hist_s dd_frame;
  logic [1:0] ack_prec_q;
  logic dd_done;
  logic dd_dup;
  logic dd_purged;
  logic dd_done_q;
  wire dd_check = wr_daf_c & wd[16];
  wire dd_purge = wr_daf_c & wd[17] & ~wd[16];

  // The octet count rides in the same write as the check, so it is taken
  // straight from the bus; the register copy would still hold the old one.
  always_comb begin
    dd_frame = rx_hist_q;
    if (wr_daf_c) begin
      dd_frame.octets = wd[11:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_hist_q <= '0;
      ack_prec_q <= 2'h0;
    end else begin
      rx_hist_q.valid <= 1'b1;
      rx_hist_q.count <= 3'h1;
      if (wr_daf_a) begin
        rx_hist_q.sender <= wd[7:0];
        rx_hist_q.id <= wd[15:8];
        rx_hist_q.ndest <= wd[19:16];
        ack_prec_q <= wd[21:20];
      end
      if (wr_daf_b) begin
        rx_hist_q.fcs <= wd;
      end
      if (wr_daf_c) begin
        rx_hist_q.octets <= wd[11:0];
      end
    end
  end

  lspd_dedup #(
    .DEPTH(HIST_DEPTH)
  ) u_dedup (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .check_i(dd_check),
    .purge_i(dd_purge),
    .frame_i(dd_frame),
    .done_o(dd_done),
    .dup_o(dd_dup),
    .purged_o(dd_purged)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dd_done_q <= 1'b0;
    end else if (dd_check) begin
      dd_done_q <= 1'b0;
    end else if (dd_done) begin
      dd_done_q <= 1'b1;
    end
  end

  // Read multiplexer; unmapped offsets read zero.
  wire [31:0] rd_status = {1'b0, clack_bad_q, nr_err_q, hold_ok_q,
                           clack_pend_q, ~win_open, cur_fpend, cur_poll_out,
                           1'b0, cur_va, 1'b0, cur_vr, 1'b0, cur_vs};
  wire [31:0] rd_diatx = {id_ready, daf_refused_q, 20'h00000,
                          daf_prec_q, daf_id_q};
  wire [31:0] rd_dires = {dd_done_q, 21'h0, ack_prec_q,
                          dd_done_q & ~dd_dup, dd_purged, dd_dup,
                          rx_hist_q.id[4:0]};
  wire [31:0] rd_data =
    (wb_adr_i == lspd_pkg::ADR_CONN_SEL) ? 32'(conn_q) :
    (wb_adr_i == lspd_pkg::ADR_TX_WORD) ? tx_word_q :
    (wb_adr_i == lspd_pkg::ADR_STATUS) ? rd_status :
    (wb_adr_i == lspd_pkg::ADR_QUEUE) ? {30'h0, queue_hi_q} :
    (wb_adr_i == lspd_pkg::ADR_DAF_TX) ? rd_diatx :
    (wb_adr_i == lspd_pkg::ADR_DAF_RES) ? rd_dires :
    32'h0000_0000;

  // Every access is answered one cycle after the request, so a read of a
  // result sees all effects of any earlier write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  assign wb_ack_o = ack_q;
endmodule : lspd_top
`default_nettype wire

// ---- hw/lspd_pkg.sv ----
// Shared constants and types for the link sequence, poll and dedup block.
package lspd_pkg;
  localparam int unsigned SEQ_W = 7;
  localparam logic [6:0] SEQ_MAX_OUT = 7'h7F;
  localparam int unsigned ID_W = 8;
  localparam logic [7:0] ID_MIN = 8'h01;
  localparam logic [7:0] ID_MAX = 8'hFF;
  localparam logic [2:0] DUP_RX_LIMIT = 3'h7;
  localparam logic [7:0] S_RR_LOW = 8'h01;
  // Register byte offsets.
  localparam logic [7:0] ADR_CONN_SEL = 8'h00;
  localparam logic [7:0] ADR_TX_REQ = 8'h04;
  localparam logic [7:0] ADR_TX_WORD = 8'h08;
  localparam logic [7:0] ADR_RX_FRAME = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_POLL_EV = 8'h14;
  localparam logic [7:0] ADR_QUEUE = 8'h18;
  localparam logic [7:0] ADR_DAF_TX = 8'h1C;
  localparam logic [7:0] ADR_DAF_RX_A = 8'h20;
  localparam logic [7:0] ADR_DAF_RX_B = 8'h24;
  localparam logic [7:0] ADR_DAF_RX_C = 8'h28;
  localparam logic [7:0] ADR_DAF_RES = 8'h2C;
  // Field positions shared by several registers.
  localparam int unsigned F_NR = 8;
  localparam int unsigned F_PF = 15;
  localparam int unsigned F_FCSOK = 16;
  localparam int unsigned F_GROUP = 17;
  localparam int unsigned F_CR = 18;
  localparam int unsigned F_IFRAME = 19;
  localparam int unsigned F_CLACK = 20;
  localparam int unsigned F_VA = 16;
  // Precedence levels and queue positions.
  localparam logic [1:0] PREC_PRIORITY = 2'h1;
  localparam logic [1:0] PREC_TOP = 2'h3;
  localparam logic [1:0] QPOS_NORMAL = 2'h0;
  localparam logic [1:0] QPOS_EARLIEST = 2'h1;
  localparam logic [1:0] QPOS_FIRST = 2'h2;

  typedef enum logic [1:0] {
    KIND_I_CMD, KIND_I_RSP, KIND_S_CMD, KIND_S_RSP
  } lspd_kind_e;

  typedef struct packed {
    logic [6:0] nr;
    logic pf;
    logic [6:0] ns;
    logic fmt;
  } lspd_ictrl_s;

  typedef struct packed {
    logic valid;
    logic [7:0] sender;
    logic [7:0] id;
    logic [31:0] fcs;
    logic [11:0] octets;
    logic [3:0] ndest;
    logic [2:0] count;
  } lspd_hist_s;
endpackage : lspd_pkg

// ---- hw/lspd_idalloc.sv ----
// Identification number allocator for outstanding decoupled data frames.
`timescale 1ns/1ns
`default_nettype none
module lspd_idalloc (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic assign_i,
  input wire logic release_i,
  input wire logic [7:0] release_id_i,
  output logic ready_o,
  output logic [7:0] id_o
);
  logic [255:0] busy_q;
  logic [7:0] cur_q;
  logic [7:0] cur_nxt;
  logic take;

  assign ready_o = ~busy_q[cur_q];
  assign id_o = cur_q;
  assign take = assign_i & ready_o;
  assign cur_nxt = (cur_q == lspd_pkg::ID_MAX) ? lspd_pkg::ID_MIN
                                               : cur_q + 8'h01;

  // The scan skips one busy number per cycle, so a request may be refused
  // briefly after a burst of assignments even though a number is free.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= '0;
      cur_q <= lspd_pkg::ID_MIN;
    end else begin
      if (release_i) begin
        busy_q[release_id_i] <= 1'b0;
      end
      if (take) begin
        busy_q[cur_q] <= 1'b1;
      end
      if (take || busy_q[cur_q]) begin
        cur_q <= cur_nxt;
      end
    end
  end
endmodule : lspd_idalloc
`default_nettype wire

// ---- hw/lspd_dedup.sv ----
// History table and duplicate detection for received decoupled data frames.
`timescale 1ns/1ns
`default_nettype none
module lspd_dedup #(
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic check_i,
  input wire logic purge_i,
  input wire lspd_pkg::lspd_hist_s frame_i,
  output logic done_o,
  output logic dup_o,
  output logic purged_o
);
  localparam int unsigned IW = $clog2(DEPTH);
  lspd_pkg::lspd_hist_s hist_q [DEPTH];
  logic [DEPTH-1:0] match;
  logic [DEPTH-1:0] same_sender;
  logic [IW-1:0] hit_idx;
  logic [IW-1:0] free_idx;
  logic [IW-1:0] rr_q;
  logic hit;
  logic have_free;
  logic is_dup;
  lspd_pkg::lspd_hist_s he;

  for (genvar g = 0; g < DEPTH; g++) begin : g_cmp
    assign same_sender[g] = hist_q[g].valid &
                            (hist_q[g].sender == frame_i.sender);
    assign match[g] = same_sender[g] &
                      (hist_q[g].id == frame_i.id);
  end

  always_comb begin
    hit_idx = '0;
    free_idx = '0;
    have_free = 1'b0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (match[i]) begin
        hit_idx = IW'(i);
      end
      if (!hist_q[i].valid) begin
        free_idx = IW'(i);
        have_free = 1'b1;
      end
    end
  end

  assign hit = |match;
  assign he = hist_q[hit_idx];
  assign is_dup = hit && (frame_i.octets == he.octets) &&
                  (he.count < lspd_pkg::DUP_RX_LIMIT) &&
                  ((frame_i.ndest < he.ndest) ||
                   ((frame_i.ndest == he.ndest) &&
                    (frame_i.fcs == he.fcs)));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        hist_q[i] <= '0;
      end
      rr_q <= '0;
      done_o <= 1'b0;
      dup_o <= 1'b0;
      purged_o <= 1'b0;
    end else begin
      done_o <= check_i;
      if (check_i) begin
        dup_o <= is_dup;
        purged_o <= hit & ~is_dup;
      end else if (purge_i) begin
        purged_o <= 1'b1;
        dup_o <= 1'b0;
      end
      if (purge_i || (check_i && hit && !is_dup)) begin
        for (int i = 0; i < DEPTH; i++) begin
          if (same_sender[i]) begin
            hist_q[i].valid <= 1'b0;
          end
        end
      end
      if (check_i && is_dup) begin
        hist_q[hit_idx].count <= he.count + 3'h1;
      end else if (check_i && hit) begin
        hist_q[hit_idx] <= frame_i;
      end else if (check_i) begin
        // A full table evicts round robin; the depth stays below the
        // per-sender ceiling so no sender can exceed it.
        hist_q[have_free ? free_idx : rr_q] <= frame_i;
        if (!have_free) begin
          rr_q <= rr_q + IW'(1);
        end
      end
    end
  end
endmodule : lspd_dedup
`default_nettype wire

// ---- testbench/lspd_remote.sv ----
// Far station model that numbers the information frames it sends us.
`timescale 1ns/1ns
`default_nettype none
module lspd_remote (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sent_i,
  input wire logic [6:0] nr_i,
  input wire logic pf_i,
  input wire logic cr_i,
  output logic [31:0] frame_o
);
  logic [6:0] vs_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vs_q <= 7'h00;
    end else if (sent_i) begin
      vs_q <= vs_q + 7'h01;
    end
  end
  // The poll bit is left to the bench, so one poll at a time is its duty.
  assign frame_o = {12'h000, 1'b1, cr_i, 2'h1,
                    pf_i, nr_i, 1'b0, vs_q};
endmodule : lspd_remote
`default_nettype wire

// ---- testbench/lspd_checker.sv ----
// Timing and field checks on the register port of the link block.
`timescale 1ns/1ns
`default_nettype none
module lspd_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  logic rd_q;
  logic [7:0] adr_q;
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic rd_ack = wb_ack_o && rd_q;
  wire logic tx_rd = rd_ack && wb_dat_o[31] &&
                     adr_q == lspd_pkg::ADR_TX_WORD;
  wire logic res_rd = rd_ack && wb_dat_o[31] &&
                      adr_q == lspd_pkg::ADR_DAF_RES;
  wire logic st_rd = rd_ack && adr_q == lspd_pkg::ADR_STATUS;
  wire logic id_rd = rd_ack && adr_q == lspd_pkg::ADR_DAF_TX;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_q <= 1'b0;
      adr_q <= 8'h00;
    end else if (take) begin
      rd_q <= !wb_we_i;
      adr_q <= wb_adr_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_timing_a: assert property (take |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |-> $past(take) ##1 !wb_ack_o)
    else $error("ack not a single pulse after a request");
  first_top_a: assert property (tx_rd && wb_dat_o[19:18] == 2'h2 |->
    wb_dat_o[17:16] == lspd_pkg::PREC_TOP && wb_dat_o[8])
    else $error("final response lacks top precedence");
  early_prec_a: assert property (tx_rd && wb_dat_o[19:18] == 2'h1 |->
    wb_dat_o[17:16] >= lspd_pkg::PREC_PRIORITY) else $error("low precedence");
  sformat_a: assert property (tx_rd && wb_dat_o[0] |->
    wb_dat_o[7:0] == lspd_pkg::S_RR_LOW) else $error("bad control field");
  id_range_a: assert property (id_rd |-> wb_dat_o[7:0] != 8'h00)
    else $error("identification number zero");
  window_full_a: assert property (st_rd |->
    wb_dat_o[26] == ((wb_dat_o[6:0] - wb_dat_o[22:16]) == 7'h7F))
    else $error("window flag wrong");
  dup_deliver_a: assert property (res_rd |->
    wb_dat_o[7] != wb_dat_o[5])
    else $error("duplicate delivered or fresh frame held");
  purge_fresh_a: assert property (res_rd && wb_dat_o[6] |->
    !wb_dat_o[5]) else $error("purged frame called duplicate");
  unmapped_a: assert property (rd_ack && adr_q >= 8'h30 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  cover property (tx_rd && wb_dat_o[19:18] == 2'h2);
  cover property (res_rd && wb_dat_o[5]);
  cover property (st_rd && wb_dat_o[26]);
endmodule : lspd_checker
bind lspd_top lspd_checker i_lspd_checker (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire

// ---- testbench/lspd_tb_top.sv ----
// Self-checking bench for the link sequence, poll and dedup block.
`timescale 1ns/1ns
`default_nettype none
module lspd_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic sent = 1'b0;
  logic [31:0] rframe;
  logic [31:0] q;
  int err_count = 0;
  int n_tests = 0;
  always #10 clk_i = ~clk_i;
  lspd_top i_lspd_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  lspd_remote i_lspd_remote (.clk_i(clk_i), .rst_i(rst_i), .sent_i(sent),
    .nr_i(7'h01), .pf_i(1'b0), .cr_i(1'b0), .frame_o(rframe));
  task automatic stop_test;
    $display("Checks %0d, errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  // The request is held until ack is seen; after 50 cycles without one it is a timeout error.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) begin
      err_count++;
      $display("Error bus ack expected 1 seen timeout");
      stop_test();
    end
  endtask : bus
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic tx(input logic [31:0] r);
    bus(1'b1, lspd_pkg::ADR_TX_REQ, r);
    rd(lspd_pkg::ADR_TX_WORD);
  endtask : tx
  task automatic s_misc;
    rd(lspd_pkg::ADR_STATUS);
    chk("status reset", 32'h0, q);
    bus(1'b1, lspd_pkg::ADR_CONN_SEL, 32'h1);
    rd(lspd_pkg::ADR_CONN_SEL);
    chk("conn sel", 32'h1, q);
    rd(8'h3C);
    chk("unmapped", 32'h0, q);
    bus(1'b1, lspd_pkg::ADR_CONN_SEL, 32'h0);
  endtask : s_misc
  task automatic s_seq;
    tx(32'h0);
    chk("first i ctrl", 32'h8000_0000, q & 32'hC000_FFFF);
    bus(1'b1, lspd_pkg::ADR_RX_FRAME, rframe);
    sent <= 1'b1;
    @(posedge clk_i);
    sent <= 1'b0;
    bus(1'b1, lspd_pkg::ADR_RX_FRAME, 32'h0009_0005);
    bus(1'b1, lspd_pkg::ADR_RX_FRAME, rframe & 32'hFFFE_FFFF);
    bus(1'b1, lspd_pkg::ADR_RX_FRAME, rframe | 32'h0002_0000);
    rd(lspd_pkg::ADR_STATUS);
    chk("counters", 32'h2001_0101, q & 32'h207F_7F7F);
    tx(32'h0);
    chk("second i ctrl", 32'h8000_0202, q & 32'hC000_FFFF);
    tx(32'hC);
    chk("group ctrl", 32'h8000_0000, q & 32'hC000_FFFF);
  endtask : s_seq
  task automatic s_window;
    for (int i = 0; i < 126; i++) begin
      bus(1'b1, lspd_pkg::ADR_TX_REQ, 32'h0);
    end
    tx(32'h0);
    chk("window refuse", 32'h4000_0000, q & 32'hC000_0000);
    rd(lspd_pkg::ADR_STATUS);
    chk("window full", 32'h0401_0000, q & 32'h047F_007F);
    bus(1'b1, lspd_pkg::ADR_RX_FRAME, 32'h0005_0000);
    tx(32'h0);
    chk("wrapped ns", 32'h8000_0200, q & 32'hC000_FFFF);
  endtask : s_window
  task automatic s_poll;
    tx(32'h8);
    chk("poll set", 32'h100, q & 32'h100);
    tx(32'h8);
    chk("poll held", 32'h0, q & 32'h100);
    bus(1'b1, lspd_pkg::ADR_POLL_EV, 32'h1);
    tx(32'h8);
    chk("poll again", 32'h100, q & 32'h100);
    bus(1'b1, lspd_pkg::ADR_RX_FRAME, 32'h0005_8000);
    rd(lspd_pkg::ADR_STATUS);
    chk("poll cleared", 32'h0, q & 32'h0100_0000);
    bus(1'b1, lspd_pkg::ADR_RX_FRAME, 32'h0001_8000);
    tx(32'h3);
    chk("final rsp", 32'h800B_0301, q & 32'hC00F_FFFF);
    bus(1'b1, lspd_pkg::ADR_QUEUE, 32'h0);
    tx(32'h3);
    chk("free rsp", 32'h8005_0201, q & 32'hC00F_FFFF);
    bus(1'b1, lspd_pkg::ADR_QUEUE, 32'h2);
    tx(32'h3);
    chk("queued prec", 32'h8006_0201, q & 32'hC00F_FFFF);
    tx(32'h2);
    chk("s cmd", 32'h8000_0201, q & 32'hC00F_FFFF);
  endtask : s_poll
  task automatic s_clack;
    tx(32'h43);
    chk("clack early", 32'h4000_0000, q & 32'hC000_0000);
    bus(1'b1, lspd_pkg::ADR_RX_FRAME, 32'h0011_8000);
    bus(1'b1, lspd_pkg::ADR_POLL_EV, 32'h2);
    tx(32'h43);
    chk("clack final", 32'h8000_0100, q & 32'hC000_0100);
    bus(1'b1, lspd_pkg::ADR_RX_FRAME, 32'h0011_0000);
    rd(lspd_pkg::ADR_STATUS);
    chk("clack no poll", 32'h4000_0000, q & 32'h4000_0000);
  endtask : s_clack
  task automatic s_ids;
    bus(1'b1, lspd_pkg::ADR_DAF_TX, 32'h1);
    rd(lspd_pkg::ADR_DAF_TX);
    chk("id one", 32'h001, q & 32'h3FF);
    bus(1'b1, lspd_pkg::ADR_DAF_TX, 32'h1);
    bus(1'b1, lspd_pkg::ADR_DAF_TX, 32'h102);
    bus(1'b1, lspd_pkg::ADR_DAF_TX, 32'h21);
    rd(lspd_pkg::ADR_DAF_TX);
    chk("id three", 32'h203, q & 32'h3FF);
  endtask : s_ids
  task automatic daf(input logic [31:0] a, input logic [31:0] b,
                     input logic [31:0] c, input logic [31:0] e);
    bus(1'b1, lspd_pkg::ADR_DAF_RX_A, a);
    bus(1'b1, lspd_pkg::ADR_DAF_RX_B, b);
    bus(1'b1, lspd_pkg::ADR_DAF_RX_C, c);
    rd(lspd_pkg::ADR_DAF_RES);
    chk("dedup result", e, q & 32'h8000_03E0);
  endtask : daf
  task automatic s_dedup;
    daf(32'h0022_0905, 32'h1234_5678, 32'h1_000A, 32'h8000_0280);
    daf(32'h0022_0905, 32'h1234_5678, 32'h1_000A, 32'h8000_0220);
    daf(32'h0021_0905, 32'hFFFF_0000, 32'h1_000A, 32'h8000_0220);
    daf(32'h0022_0905, 32'hAAAA_0000, 32'h1_000A, 32'h8000_02C0);
    daf(32'h0022_0905, 32'hAAAA_0000, 32'h1_000B, 32'h8000_02C0);
    bus(1'b1, lspd_pkg::ADR_DAF_RX_C, 32'h2_0000);
    daf(32'h0022_0905, 32'hAAAA_0000, 32'h1_000B, 32'h8000_0280);
    for (int i = 0; i < 6; i++) begin
      daf(32'h0022_0905, 32'hAAAA_0000, 32'h1_000B, 32'h8000_0220);
    end
    daf(32'h0022_0905, 32'hAAAA_0000, 32'h1_000B, 32'h8000_02C0);
  endtask : s_dedup
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    s_misc();
    s_seq();
    s_window();
    s_poll();
    s_clack();
    s_ids();
    s_dedup();
    stop_test();
  end
endmodule : lspd_tb_top
`default_nettype wire
